// ---- adc_output_clocking_and_control_modes_bench.sv ----
/*
 Self-checking bench: a row table of control modes, then power-down cases.
 Assumes converter_pkg, the capture model and the bound checker.
*/
`timescale 1ns/1ps
module adc_output_clocking_and_control_modes_bench;
	import converter_pkg::*;
	localparam int SHORT = 20;
	localparam int LONG  = 40;
	localparam int RUN   = 30;
	typedef struct packed {
		logic        ext, flt, edg, rng, swing, cdly, wr;
		logic [15:0] cfg, fs, off;
		logic        amp;
		logic [8:0]  fs_step, off_step;
		logic [2:0]  period;
	} row_type;
	logic       clock, rstn = 1'b0, serial_clock = 1'b0, serial_select_n = 1'b1, serial_data = 1'b0;
	logic       power_down_pin = 1'b0, calibration_request_pin = 1'b1, clock_edge_select_pin = 1'b0;
	logic       clock_edge_select_float = 1'b0, full_scale_range_pin = 1'b0, extended_control_select = 1'b0;
	logic       cal_delay_select = 1'b0, output_swing_select = 1'b0, sample_over_range = 1'b0;
	logic       output_data_clock_q, outputs_enable_q, amplitude_bit_q, calibration_running_q, powered_down_q;
	logic       out_of_range_q;
	logic [7:0] sample_in = 8'h00, bus_a_q, bus_b_q;
	logic [8:0] full_scale_step_q, offset_step_q;
	int         mismatches = 0, n_checks = 0, words, errors;
	row_type    rows [7] = '{
		'{0, 1, 0, 1, 1, 0, 0, 16'h0000, 16'h0000, 16'h0000, 1, 9'h100, 9'h000, 3'h4},
		'{0, 0, 1, 0, 0, 1, 0, 16'h0000, 16'h0000, 16'h0000, 0, 9'h080, 9'h000, 3'h2},
		'{0, 0, 0, 1, 1, 0, 0, 16'h0000, 16'h0000, 16'h0000, 1, 9'h100, 9'h000, 3'h2},
		'{1, 0, 1, 0, 0, 1, 0, 16'h0000, 16'h0000, 16'h0000, 1, 9'h100, 9'h000, 3'h4},
		'{1, 0, 0, 0, 0, 0, 1, 16'hB7FF, 16'hFF80, 16'h0080, 1, 9'h1FF, 9'h001, 3'h2},
		'{1, 0, 0, 0, 0, 0, 1, 16'hB4FF, 16'h0000, 16'hFF80, 0, 9'h000, 9'h1FF, 3'h2},
		'{1, 0, 0, 0, 0, 0, 1, 16'hBAFF, 16'h8000, 16'h0000, 1, 9'h100, 9'h000, 3'h4}};

	converter_control #(.CAL_DELAY_SHORT_CYCLES(SHORT), .CAL_DELAY_LONG_CYCLES(LONG), .CAL_RUN_CYCLES(RUN)) dut_u (
		.clock(clock), .rstn(rstn), .serial_clock(serial_clock), .serial_select_n(serial_select_n),
		.serial_data(serial_data), .power_down_pin(power_down_pin), .calibration_request_pin(calibration_request_pin),
		.clock_edge_select_pin(clock_edge_select_pin), .clock_edge_select_float(clock_edge_select_float),
		.full_scale_range_pin(full_scale_range_pin), .extended_control_select(extended_control_select),
		.cal_delay_select(cal_delay_select), .output_swing_select(output_swing_select), .sample_in(sample_in),
		.sample_over_range(sample_over_range), .bus_a_q(bus_a_q), .bus_b_q(bus_b_q), .out_of_range_q(out_of_range_q),
		.output_data_clock_q(output_data_clock_q), .outputs_enable_q(outputs_enable_q),
		.amplitude_bit_q(amplitude_bit_q), .calibration_running_q(calibration_running_q),
		.powered_down_q(powered_down_q), .full_scale_step_q(full_scale_step_q), .offset_step_q(offset_step_q));
	capture_receiver rx_u (.data_clock(output_data_clock_q), .valid(outputs_enable_q && !calibration_running_q),
		.bus_a(bus_a_q), .bus_b(bus_b_q), .words(words), .errors(errors));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Counting samples from the conversion core
	always @(posedge clock)
	begin
		sample_in         <= sample_in + 8'h01;
		sample_over_range <= sample_in == 8'hFE;
	end

	task automatic check(input logic ok, input string what);
		n_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic pick(input int sel);
		return sel == 0 ? calibration_running_q : (sel == 1 ? powered_down_q : outputs_enable_q);
	endfunction
	// Bounded wait for a status output to reach a level
	task automatic wait_for(input int sel, input logic lvl, output int cnt);
		cnt = 0;
		while (pick(sel) !== lvl)
		begin
			@(posedge clock);
			#1;
			cnt++;
			if (cnt > 3000)
			begin
				check(1'b0, "wait timed out");
				tally_and_finish();
			end
		end
	endtask
	task automatic ser_write(input logic [3:0] addr, input logic [15:0] value);
		logic [31:0] frame;
		frame = {FRAME_HEADER, addr, value};
		serial_select_n <= 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			serial_data <= frame[i];
			#3 serial_clock <= 1'b1;
			#3 serial_clock <= 1'b0;
		end
		#3 serial_select_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
	task automatic pulse_reset;
		rstn <= 1'b0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
	endtask
	task automatic cal_cmd;
		calibration_request_pin <= 1'b0;
		repeat (90) @(posedge clock);
		calibration_request_pin <= 1'b1;
		repeat (90) @(posedge clock);
		#1;
	endtask

	initial
	begin
		row_type r;
		int      d;
		int      e;
		int      p;
		logic    prev;
		foreach (rows[i])
		begin
			r = rows[i];
			e = (!r.ext && r.cdly) ? LONG : SHORT;
			@(posedge clock);
			extended_control_select <= r.ext;
			clock_edge_select_float <= r.flt;
			clock_edge_select_pin   <= r.edg;
			full_scale_range_pin    <= r.rng;
			output_swing_select     <= r.swing;
			cal_delay_select        <= r.cdly;
			pulse_reset();
			wait_for(0, 1'b1, d);
			check(d >= e && d <= e + 8, "power-on calibration delay");
			wait_for(0, 1'b0, d);
			check(d >= RUN - 1 && d <= RUN + 3, "calibration length");
			if (r.wr)
			begin
				ser_write(ADDR_OUTPUT_CFG, r.cfg);
				ser_write(ADDR_FULL_SCALE, r.fs);
				ser_write(ADDR_OFFSET_ADJ, r.off);
			end
			repeat (20) @(posedge clock);
			#1;
			p    = 0;
			prev = output_data_clock_q;
			repeat (40)
			begin
				@(posedge clock);
				#1;
				p    = p + ((output_data_clock_q === 1'b1 && prev === 1'b0) ? 1 : 0);
				prev = output_data_clock_q;
			end
			check(p == 40 / r.period, "data clock rate");
			check(amplitude_bit_q === r.amp, "amplitude");
			check(full_scale_step_q === r.fs_step, "full scale step");
			check(offset_step_q === r.off_step, "offset step");
			$display("row %0d done", i);
		end
		ser_write(4'h4, 16'h0000);
		check(full_scale_step_q === STEP_NORMAL_RANGE && amplitude_bit_q === 1'b1, "reserved write");
		$display("reserved address test done");
		@(posedge clock);
		power_down_pin <= 1'b1;
		wait_for(1, 1'b1, d);
		check(outputs_enable_q === 1'b0 && d <= 6, "power down");
		cal_cmd();
		@(posedge clock);
		power_down_pin <= 1'b0;
		wait_for(2, 1'b1, d);
		repeat (100) @(posedge clock);
		#1;
		check(calibration_running_q === 1'b0, "request in power down");
		cal_cmd();
		wait_for(0, 1'b1, d);
		@(posedge clock);
		power_down_pin <= 1'b1;
		repeat (5) @(posedge clock);
		#1;
		check(powered_down_q === 1'b0, "power down deferred");
		wait_for(0, 1'b0, d);
		wait_for(1, 1'b1, d);
		check(d <= 4, "power down after calibration");
		pulse_reset();
		repeat (100) @(posedge clock);
		#1;
		check(calibration_running_q === 1'b0, "calibration held off");
		@(posedge clock);
		power_down_pin <= 1'b0;
		wait_for(0, 1'b1, d);
		check(d >= SHORT && d <= SHORT + 8, "calibration after power down");
		wait_for(0, 1'b0, d);
		repeat (60) @(posedge clock);
		check(words > 0 && errors == 0, "captured word pairs");
		p = 0;
		repeat (300)
		begin
			@(posedge clock);
			#1;
			p = p | ((out_of_range_q === 1'b1) ? 1 : 0);
		end
		check(p == 1, "out of range flag");
		$display("power down tests done");
		tally_and_finish();
	end
endmodule

// ---- capture_receiver.sv ----
/*
 Downstream capture model: takes both buses on each data clock edge.
 Assumes bus words settle within 2 ns of the data clock edge.
*/
`timescale 1ns/1ps
module capture_receiver (
	input  wire logic       data_clock,
	input  wire logic       valid,
	input  wire logic [7:0] bus_a,
	input  wire logic [7:0] bus_b,
	output int              words,
	output int              errors
);
	int skip = 16;
	initial
	begin
		words  = 0;
		errors = 0;
	end
	// Interleave older bus B then bus A
	always @(data_clock or negedge valid)
	begin
		#2;
		if (!valid)
			skip = 16;
		else if (skip > 0)
			skip = skip - 1;
		else
		begin
			words = words + 2;
			if (bus_a !== bus_b + 8'h01)
				errors = errors + 1;
		end
	end
endmodule

// ---- converter_control.sv ----
/*
 Output clocking, power-down, calibration sequencing and control mode logic
 of the converter, with the extended registers written over the serial port.
 Assumes samples arrive once per converter clock from the conversion core,
 pins are asynchronous, and the serial clock is unrelated to the main clock.
*/
`timescale 1ns/1ps
module converter_control
	import converter_pkg::*;
#(
	parameter int CAL_DELAY_SHORT_CYCLES = 16777216,
	parameter int CAL_DELAY_LONG_CYCLES  = 268435456,
	parameter int CAL_RUN_CYCLES         = 1400000
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       serial_clock,
	input  wire logic       serial_select_n,
	input  wire logic       serial_data,
	input  wire logic       power_down_pin,
	input  wire logic       calibration_request_pin,
	input  wire logic       clock_edge_select_pin,
	input  wire logic       clock_edge_select_float,
	input  wire logic       full_scale_range_pin,
	input  wire logic       extended_control_select,
	input  wire logic       cal_delay_select,
	input  wire logic       output_swing_select,
	input  wire logic [7:0] sample_in,
	input  wire logic       sample_over_range,
	output logic      [7:0] bus_a_q,
	output logic      [7:0] bus_b_q,
	output logic            out_of_range_q,
	output logic            output_data_clock_q,
	output logic            outputs_enable_q,
	output logic            amplitude_bit_q,
	output logic            calibration_running_q,
	output logic            powered_down_q,
	output logic      [8:0] full_scale_step_q,
	output logic      [8:0] offset_step_q
);

	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] pins;
	logic [19:0]          serial_word;
	logic                 serial_toggle;
	logic                 toggle_seen_q;
	logic                 word_arrived;

	logic [15:0]          output_cfg_q;
	logic [15:0]          offset_adj_q;
	logic [15:0]          full_scale_q;

	power_state_type      state_q;
	power_state_type      state_d;
	logic [31:0]          timer_q;
	logic [31:0]          delay_target;
	logic                 timer_done;
	logic [7:0]           cal_low_cnt_q;
	logic [7:0]           cal_high_cnt_q;
	logic                 cal_armed_q;
	logic                 cal_command;

	logic                 extended;
	logic                 double_rate;
	logic                 rise_edge;
	logic                 phase_shift;
	logic                 running;
	logic [1:0]           phase_q;
	logic                 update;
	logic [8:0]           history_q [0:LATENCY_B-2];

	// Pins and the serial toggle cross into the converter clock
	assign pins_raw = {serial_toggle, output_swing_select, cal_delay_select,
		extended_control_select, full_scale_range_pin, clock_edge_select_float,
		clock_edge_select_pin, calibration_request_pin, power_down_pin};

	pin_sync #(
		.WIDTH (PIN_COUNT)
	) u_pin_sync (
		.clock    (clock),
		.rstn     (rstn),
		.async_in (pins_raw),
		.sync_out (pins)
	);

	serial_receiver u_serial_receiver (
		.serial_clock  (serial_clock),
		.rstn          (rstn),
		.select_n      (serial_select_n),
		.serial_data   (serial_data),
		.word_q        (serial_word),
		.word_toggle_q (serial_toggle)
	);

	// Control mode choice
	assign extended = pins[PIN_EXTENDED];

	// Edge of the announcing toggle marks a new stable word
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			toggle_seen_q <= 1'b0;
		end
		else
		begin
			toggle_seen_q <= pins[PIN_WORD_TOGGLE];
		end
	end

	assign word_arrived = pins[PIN_WORD_TOGGLE] ^ toggle_seen_q;

	// Extended registers; writes only take effect in extended mode
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			output_cfg_q <= OUTPUT_CFG_RESET;
			offset_adj_q <= OFFSET_RESET;
			full_scale_q <= FULL_SCALE_RESET;
		end
		else if (word_arrived && extended)
		begin
			case (serial_word[19:16])
				ADDR_OUTPUT_CFG:
				begin
					output_cfg_q <= serial_word[15:0];
				end
				ADDR_OFFSET_ADJ:
				begin
					offset_adj_q <= serial_word[15:0];
				end
				ADDR_FULL_SCALE:
				begin
					full_scale_q <= serial_word[15:0];
				end
				default:
				begin
					output_cfg_q <= output_cfg_q;
				end
			endcase
		end
	end

	// Clocking choices per control mode
	always_comb
	begin
		if (extended)
		begin
			double_rate = ~output_cfg_q[CFG_RATE_BIT];
			rise_edge   = output_cfg_q[CFG_EDGE_BIT];
			phase_shift = output_cfg_q[CFG_PHASE_BIT];
		end
		else
		begin
			double_rate = pins[PIN_EDGE_FLOAT];
			rise_edge   = pins[PIN_EDGE];
			phase_shift = 1'b0;
		end
	end

	// Power-on calibration delay; extended mode uses the short one
	assign delay_target = (!extended && pins[PIN_CAL_DELAY]) ? 32'(CAL_DELAY_LONG_CYCLES)
		: 32'(CAL_DELAY_SHORT_CYCLES);

	always_comb
	begin
		timer_done = 1'b0;
		if (state_q == ST_WAIT_POWER)
		begin
			timer_done = (timer_q >= delay_target - 32'h1);
		end
		else if (state_q == ST_CALIBRATE)
		begin
			timer_done = (timer_q >= 32'(CAL_RUN_CYCLES) - 32'h1);
		end
	end

	// Manual calibration: low for a while, then high for a while
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cal_low_cnt_q  <= '0;
			cal_high_cnt_q <= '0;
			cal_armed_q    <= 1'b0;
		end
		else if (state_q != ST_ACTIVE || pins[PIN_POWER_DOWN])
		begin
			cal_low_cnt_q  <= '0;
			cal_high_cnt_q <= '0;
			cal_armed_q    <= 1'b0;
		end
		else if (!pins[PIN_CAL_REQ])
		begin
			cal_high_cnt_q <= '0;
			if (cal_low_cnt_q < 8'(CAL_LOW_CYCLES))
			begin
				cal_low_cnt_q <= cal_low_cnt_q + 8'h01;
			end
			else
			begin
				cal_armed_q <= 1'b1;
			end
		end
		else
		begin
			cal_low_cnt_q <= '0;
			if (cal_armed_q && cal_high_cnt_q < 8'(CAL_HIGH_CYCLES))
			begin
				cal_high_cnt_q <= cal_high_cnt_q + 8'h01;
			end
			else if (!cal_armed_q)
			begin
				cal_high_cnt_q <= '0;
			end
		end
	end

	assign cal_command = cal_armed_q && cal_high_cnt_q == 8'(CAL_HIGH_CYCLES);

	// Power and calibration sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_WAIT_POWER:
			begin
				if (!pins[PIN_POWER_DOWN] && timer_done)
				begin
					state_d = ST_CALIBRATE;
				end
			end
			ST_ACTIVE:
			begin
				if (pins[PIN_POWER_DOWN])
				begin
					state_d = ST_DOWN;
				end
				else if (cal_command)
				begin
					state_d = ST_CALIBRATE;
				end
			end
			ST_CALIBRATE:
			begin
				if (timer_done)
				begin
					state_d = pins[PIN_POWER_DOWN] ? ST_DOWN : ST_ACTIVE;
				end
			end
			ST_DOWN:
			begin
				if (!pins[PIN_POWER_DOWN])
				begin
					state_d = ST_ACTIVE;
				end
			end
			default:
			begin
				state_d = ST_WAIT_POWER;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ST_WAIT_POWER;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Shared timer: power-on delay counts only while power-down is low
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			timer_q <= '0;
		end
		else if (state_d != state_q)
		begin
			timer_q <= '0;
		end
		else if (state_q == ST_WAIT_POWER && pins[PIN_POWER_DOWN])
		begin
			timer_q <= timer_q;
		end
		else if (state_q == ST_WAIT_POWER || state_q == ST_CALIBRATE)
		begin
			timer_q <= timer_q + 32'h1;
		end
	end

	// Word phase; all output timing halts outside the active state
	assign running = (state_q == ST_ACTIVE);
	assign update  = phase_q[0];

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			phase_q <= '0;
		end
		else if (running)
		begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// Output data clock
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			output_data_clock_q <= 1'b0;
		end
		else if (running && double_rate)
		begin
			if (update ^ phase_shift)
			begin
				output_data_clock_q <= ~output_data_clock_q;
			end
		end
		else if (running)
		begin
			output_data_clock_q <= rise_edge ? update : ~update;
		end
	end

	// Sample history feeding both buses
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < LATENCY_B - 1; i++)
			begin
				history_q[i] <= '0;
			end
		end
		else if (running)
		begin
			history_q[0] <= {sample_over_range, sample_in};
			for (int i = 1; i < LATENCY_B - 1; i++)
			begin
				history_q[i] <= history_q[i-1];
			end
		end
	end

	// Both buses change together once per word
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			bus_a_q        <= '0;
			bus_b_q        <= '0;
			out_of_range_q <= 1'b0;
		end
		else if (running && update)
		begin
			bus_a_q        <= history_q[LATENCY_A-2][7:0];
			bus_b_q        <= history_q[LATENCY_B-2][7:0];
			out_of_range_q <= history_q[LATENCY_A-2][8] | history_q[LATENCY_B-2][8];
		end
	end

	// Status and analog settings
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			outputs_enable_q      <= 1'b0;
			powered_down_q        <= 1'b0;
			calibration_running_q <= 1'b0;
			amplitude_bit_q       <= 1'b1;
			full_scale_step_q     <= STEP_NONE;
			offset_step_q         <= STEP_NONE;
		end
		else
		begin
			outputs_enable_q      <= (state_d != ST_DOWN);
			powered_down_q        <= (state_d == ST_DOWN);
			calibration_running_q <= (state_d == ST_CALIBRATE);
			amplitude_bit_q       <= extended ? output_cfg_q[CFG_AMPL_BIT] : pins[PIN_SWING];
			if (extended)
			begin
				full_scale_step_q <= full_scale_q[STEP_MSB:STEP_LSB];
				offset_step_q     <= offset_adj_q[STEP_MSB:STEP_LSB];
			end
			else
			begin
				full_scale_step_q <= pins[PIN_RANGE] ? STEP_NORMAL_RANGE : STEP_REDUCED_RANGE;
				offset_step_q     <= STEP_NONE;
			end
		end
	end

endmodule

// ---- converter_control_checker.sv ----
/*
 Concurrent checks on the ports of converter_control.
 Assumes binding to converter_control and a single converter clock domain.
*/
`timescale 1ns/1ps
module converter_control_checker
	import converter_pkg::*;
(
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       extended_control_select,
	input wire logic       clock_edge_select_pin,
	input wire logic       clock_edge_select_float,
	input wire logic       full_scale_range_pin,
	input wire logic       output_swing_select,
	input wire logic [7:0] sample_in,
	input wire logic [7:0] bus_a_q,
	input wire logic [7:0] bus_b_q,
	input wire logic       output_data_clock_q,
	input wire logic       outputs_enable_q,
	input wire logic       amplitude_bit_q,
	input wire logic       calibration_running_q,
	input wire logic       powered_down_q,
	input wire logic [8:0] full_scale_step_q,
	input wire logic [8:0] offset_step_q
);
	logic [4:0] pins;
	logic [4:0] pins_q;
	logic [3:0] age_q;
	logic [4:0] run_q;
	logic       norm;
	logic       run;
	logic       sdr;
	logic       ddr;
	assign pins = {extended_control_select, clock_edge_select_pin, clock_edge_select_float, full_scale_range_pin,
		output_swing_select};
	assign norm = !extended_control_select && age_q == 4'hF;
	assign run  = run_q == 5'h1F;
	assign sdr  = norm && run && !clock_edge_select_float;
	assign ddr  = norm && run && clock_edge_select_float;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Cycles since the control pins last moved
	always_ff @(posedge clock or negedge rstn)
	begin
		pins_q <= !rstn ? 5'h00 : pins;
		age_q  <= (!rstn || pins_q != pins) ? 4'h0 : (age_q == 4'hF ? age_q : age_q + 4'h1);
	end
	// Cycles of uninterrupted output activity
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn || !outputs_enable_q || calibration_running_q)
			run_q <= 5'h00;
		else if (run_q != 5'h1F)
			run_q <= run_q + 5'h01;
	end
	property p_pd_float; powered_down_q |-> !outputs_enable_q; endproperty
	a_pd_float: assert property (p_pd_float) else $error("outputs driven in power down");
	property p_no_cal_down; powered_down_q |-> !calibration_running_q; endproperty
	a_no_cal_down: assert property (p_no_cal_down) else $error("calibration in power down");
	property p_cal_clk; calibration_running_q && $past(calibration_running_q) |-> $stable(output_data_clock_q); endproperty
	a_cal_clk: assert property (p_cal_clk) else $error("data clock moved in calibration");
	property p_cal_bus; calibration_running_q [*2] |-> $stable(bus_a_q) && $stable(bus_b_q); endproperty
	a_cal_bus: assert property (p_cal_bus) else $error("bus moved in calibration");
	property p_norm_fs; norm |-> full_scale_step_q == (full_scale_range_pin ? STEP_NORMAL_RANGE : STEP_REDUCED_RANGE); endproperty
	a_norm_fs: assert property (p_norm_fs) else $error("normal range step wrong");
	property p_norm_off; norm |-> offset_step_q == STEP_NONE; endproperty
	a_norm_off: assert property (p_norm_off) else $error("offset in normal mode");
	property p_norm_amp; norm |-> amplitude_bit_q == output_swing_select; endproperty
	a_norm_amp: assert property (p_norm_amp) else $error("amplitude not from pin");
	property p_sdr_clk; sdr && $rose(output_data_clock_q) |-> (##1 !output_data_clock_q)
		or (##[1:2] !outputs_enable_q) or (##[2:3] calibration_running_q); endproperty
	a_sdr_clk: assert property (p_sdr_clk) else $error("single rate clock period wrong");
	property p_ddr_clk; ddr && $rose(output_data_clock_q) |-> (##1 output_data_clock_q ##1 !output_data_clock_q)
		or (##[1:2] !outputs_enable_q) or (##[2:3] calibration_running_q); endproperty
	a_ddr_clk: assert property (p_ddr_clk) else $error("double rate clock period wrong");
	property p_sdr_edge; sdr && $changed(bus_a_q) |->
		(clock_edge_select_pin ? $rose(output_data_clock_q) : $fell(output_data_clock_q)); endproperty
	a_sdr_edge: assert property (p_sdr_edge) else $error("data changed on wrong clock edge");
	property p_ddr_edge; ddr && $changed(output_data_clock_q) |-> $changed(bus_a_q); endproperty
	a_ddr_edge: assert property (p_ddr_edge) else $error("double rate edge without data");
	property p_latency; run && $changed(bus_a_q) |->
		bus_a_q == $past(sample_in, 13) && bus_b_q == $past(sample_in, 14); endproperty
	a_latency: assert property (p_latency) else $error("bus latency wrong");
endmodule

bind converter_control converter_control_checker checker_u (
	.clock(clock), .rstn(rstn), .extended_control_select(extended_control_select),
	.clock_edge_select_pin(clock_edge_select_pin), .clock_edge_select_float(clock_edge_select_float),
	.full_scale_range_pin(full_scale_range_pin), .output_swing_select(output_swing_select),
	.sample_in(sample_in), .bus_a_q(bus_a_q), .bus_b_q(bus_b_q), .output_data_clock_q(output_data_clock_q),
	.outputs_enable_q(outputs_enable_q), .amplitude_bit_q(amplitude_bit_q),
	.calibration_running_q(calibration_running_q), .powered_down_q(powered_down_q),
	.full_scale_step_q(full_scale_step_q), .offset_step_q(offset_step_q)
);

// ---- converter_pkg.sv ----
/*
 Shared constants for the converter output clocking and control block:
 register addresses, field positions, reset values, timing counts, states.
 Assumes a 100 MHz converter clock and a separate serial write clock.
*/
package converter_pkg;

	// Serial access framing
	localparam int               FRAME_BITS      = 32;
	localparam logic [11:0]      FRAME_HEADER    = 12'h001;
	localparam logic [3:0]       ADDR_OUTPUT_CFG = 4'h1;
	localparam logic [3:0]       ADDR_OFFSET_ADJ = 4'h2;
	localparam logic [3:0]       ADDR_FULL_SCALE = 4'h3;

	// Configuration register fields
	localparam int               CFG_PHASE_BIT   = 11;
	localparam int               CFG_RATE_BIT    = 10;
	localparam int               CFG_AMPL_BIT    = 9;
	localparam int               CFG_EDGE_BIT    = 8;
	localparam int               STEP_MSB        = 15;
	localparam int               STEP_LSB        = 7;

	// Power-on values of the extended registers
	localparam logic [15:0]      OUTPUT_CFG_RESET = 16'hB2FF;
	localparam logic [15:0]      OFFSET_RESET     = 16'h0000;
	localparam logic [15:0]      FULL_SCALE_RESET = 16'h8000;

	// Full scale and offset steps presented in normal control mode
	localparam logic [8:0]       STEP_NORMAL_RANGE  = 9'h100;
	localparam logic [8:0]       STEP_REDUCED_RANGE = 9'h080;
	localparam logic [8:0]       STEP_NONE          = 9'h000;

	// Calibration command, in converter clock cycles
	localparam int               CAL_LOW_CYCLES  = 80;
	localparam int               CAL_HIGH_CYCLES = 80;

	// Output latency, converter clock cycles
	localparam int               LATENCY_A       = 13;
	localparam int               LATENCY_B       = 14;

	// Synchronised pin vector layout
	localparam int               PIN_POWER_DOWN  = 0;
	localparam int               PIN_CAL_REQ     = 1;
	localparam int               PIN_EDGE        = 2;
	localparam int               PIN_EDGE_FLOAT  = 3;
	localparam int               PIN_RANGE       = 4;
	localparam int               PIN_EXTENDED    = 5;
	localparam int               PIN_CAL_DELAY   = 6;
	localparam int               PIN_SWING       = 7;
	localparam int               PIN_WORD_TOGGLE = 8;
	localparam int               PIN_COUNT       = 9;

	typedef enum logic [1:0] {
		ST_WAIT_POWER = 2'b00,
		ST_ACTIVE     = 2'b01,
		ST_CALIBRATE  = 2'b11,
		ST_DOWN       = 2'b10
	} power_state_type;

endpackage

// ---- pin_sync.sv ----
/*
 Two flip-flop synchroniser, one chain per bit.
 Assumes each bit is a level that stays long enough to be sampled.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
				begin
					meta_q[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_q[i]   <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// ---- serial_receiver.sv ----
/*
 Serial write receiver on the serial clock: 12-bit header, 4-bit address,
 16-bit value, MSB first. A framed word is held and announced by a toggle.
 Assumes chip select and data change away from the rising serial clock edge.
*/
`timescale 1ns/1ps
module serial_receiver
	import converter_pkg::*;
(
	input  wire logic        serial_clock,
	input  wire logic        rstn,
	input  wire logic        select_n,
	input  wire logic        serial_data,
	output logic      [19:0] word_q,
	output logic             word_toggle_q
);

	logic [30:0] shift_q;
	logic [4:0]  count_q;
	logic [31:0] frame;

	assign frame = {shift_q, serial_data};

	// Shift and frame counter; frames may follow back to back
	always_ff @(posedge serial_clock or negedge rstn)
	begin
		if (!rstn)
		begin
			shift_q <= '0;
			count_q <= '0;
		end
		else if (select_n)
		begin
			count_q <= '0;
		end
		else
		begin
			shift_q <= frame[30:0];
			count_q <= count_q + 5'h01;
		end
	end

	// Hold complete frames with a valid header
	always_ff @(posedge serial_clock or negedge rstn)
	begin
		if (!rstn)
		begin
			word_q        <= '0;
			word_toggle_q <= 1'b0;
		end
		else if (!select_n && count_q == 5'(FRAME_BITS - 1) && frame[31:20] == FRAME_HEADER)
		begin
			word_q        <= frame[19:0];
			word_toggle_q <= ~word_toggle_q;
		end
	end

endmodule
